// [decode_regs.vh]
`ifndef DECODE_REGS_VH
`define DECODE_REGS_VH

// instruction cycle = four oscillator periods
`define PH_W 2
`define PH_READ 2'h1
`define PH_LAST 2'h3
`define PH_STEP 2'h1

// word layout
`define WORD_W 16
`define NIB_HI 15
`define NIB_LO 12
`define NIB_SECOND 4'hF
`define OPC_HI 15
`define OPC_LO 10
`define OPC_W 6
`define D_BIT 9
`define A_BIT 8
`define BIT_HI 11
`define BIT_LO 9
`define F_HI 7
`define F_LO 0
`define F12_HI 11
`define K8_HI 7
`define K4_HI 3
`define REL11_HI 10
`define REL11_SIGN 10
`define REL8_SIGN 7
`define S_CALL_BIT 8
`define S_RET_BIT 0
`define MM_HI 1
`define MM_LO 0

// operand widths
`define ADDR_W 12
`define LIT_W 20
`define BANK_W 4
`define CNT_W 2

// instruction kinds reported by the external opcode table
`define KIND_W 4
`define K_BYTE 4'h0
`define K_BIT 4'h1
`define K_LIT8 4'h2
`define K_MOVE 4'h3
`define K_LONG 4'h4
`define K_CALL 4'h5
`define K_LIT12 4'h6
`define K_BRA_REL 4'h7
`define K_COND_REL 4'h8
`define K_RET 4'h9
`define K_TBL 4'hA
`define K_SKIP 4'hB
`define K_CTRL 4'hC

// table pointer modes
`define MM_NONE 2'h0
`define MM_POST_INC 2'h1
`define MM_POST_DEC 2'h2
`define MM_PRE_INC 2'h3

// access region and watched port register
`define ACCESS_HI_BANK 4'hF
`define ACCESS_LO_BANK 4'h0
`define PORT_B_ADDR 12'hF81

// register port
`define RA_W 3
`define RA_CTRL 3'h0
`define RA_STATUS 3'h1
`define RA_WORD_LO 3'h2
`define RA_WORD_HI 3'h3
`define CTRL_RUN 0
`define CTRL_RESET 8'h01
`define BYTE_ZERO 8'h00
`define ONE_CYC 2'h1
`define TWO_CYC 2'h2
`define THREE_CYC 2'h3

`endif

// [field_split.v]
`include "decode_regs.vh"

module field_split (
    word,
    bank_select_register,
    dest_file,
    access_bsr,
    bit_num,
    full_addr,
    tmode
);
    input wire [`WORD_W-1:0] word;
    input wire [`BANK_W-1:0] bank_select_register;
    output wire dest_file;
    output wire access_bsr;
    output wire [2:0] bit_num;
    output wire [`ADDR_W-1:0] full_addr;
    output wire [1:0] tmode;

    assign dest_file = word[`D_BIT];
    assign access_bsr = word[`A_BIT];
    assign bit_num = word[`BIT_HI:`BIT_LO];
    assign tmode = word[`MM_HI:`MM_LO];
    // a=0 maps into the fixed access region, upper half onto the top bank
    assign full_addr = word[`A_BIT] ? {bank_select_register, word[`F_HI:`F_LO]} :
        {(word[`F_HI] ? `ACCESS_HI_BANK : `ACCESS_LO_BANK), word[`F_HI:`F_LO]};
endmodule // field_split

// [instruction_word_decode.v]
// Overview of operation
// - an ordinary instruction is one 16-bit word: opcode plus operand fields.
// - four instructions use two consecutive words forming one 32-bit encoding.
// - a second word starts with 1111; executed alone it is a no-operation.
// - single-word takes one cycle, two when a test is true or the counter changes.
// - every double-word instruction other than a taken long branch takes two instruction cycles.
// - one instruction cycle is four clock periods.
// - a taken two-word branch other than a call takes three instruction cycles; a call takes two.
// - destination bit zero sends result to accumulator, one back to file register.
// - access bit zero uses access region, one takes bank from bank select register.
// - bit instructions pick bit 0 to 7 with a three-bit field.
// - single-word file address is eight bits, 0x00 to 0xFF in the bank.
// - register move carries 12-bit source and 12-bit target addresses.
// - literal is decoded as 8, 12 or 20 bits depending on instruction.
// - table mode field: no change, post-increment, post-decrement or pre-increment.
// - any file register instruction reads the register first, then writes it.
// - that read of the port register clears the port change flag, may copy pins.
// - relative branches use a two's complement offset, others a direct address.
// - mode bit one saves or restores shadow registers, zero leaves them alone.
// - byte words: opcode 15..10, destination 9, access 8, file address 7..0.
// - bit words: 4-bit opcode, three-bit bit number, access bit, 8-bit address.
// - move second word starts 1111 and holds the 12-bit target address.
`include "decode_regs.vh"

module instruction_word_decode (
    clk,
    nrst,
    prog_word,
    instr_kind,
    cond_true,
    bank_select_register,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    instr_word_r,
    opcode_r,
    file_rd_r,
    file_wr_r,
    file_addr_r,
    bit_num_r,
    dest_accum_r,
    working_accumulator_wr_r,
    literal_r,
    target_r,
    rel_offset_r,
    pc_load_r,
    fetch_discard_r,
    exec_nop_r,
    instr_done_r,
    cycles_used_r,
    shadow_save_r,
    shadow_restore_r,
    table_pointer_mode_r,
    table_op_r,
    move_source_address_r,
    move_target_address_r,
    port_change_flag_clear_r,
    port_latch_copy_r,
    phase_r
);
    input wire clk;
    input wire nrst;
    input wire [`WORD_W-1:0] prog_word;
    input wire [`KIND_W-1:0] instr_kind;
    input wire cond_true;
    input wire [`BANK_W-1:0] bank_select_register;
    input wire [`RA_W-1:0] reg_addr;
    input wire [7:0] reg_wdata;
    input wire reg_wr;
    input wire reg_rd;
    output reg [7:0] reg_rdata;
    output reg [`WORD_W-1:0] instr_word_r;
    output reg [`OPC_W-1:0] opcode_r;
    output reg file_rd_r;
    output reg file_wr_r;
    output reg [`ADDR_W-1:0] file_addr_r;
    output reg [2:0] bit_num_r;
    output reg dest_accum_r;
    output reg working_accumulator_wr_r;
    output reg [`LIT_W-1:0] literal_r;
    output reg [`LIT_W-1:0] target_r;
    output reg [`LIT_W-1:0] rel_offset_r;
    output reg pc_load_r;
    output reg fetch_discard_r;
    output reg exec_nop_r;
    output reg instr_done_r;
    output reg [`CNT_W-1:0] cycles_used_r;
    output reg shadow_save_r;
    output reg shadow_restore_r;
    output reg [1:0] table_pointer_mode_r;
    output reg table_op_r;
    output reg [`ADDR_W-1:0] move_source_address_r;
    output reg [`ADDR_W-1:0] move_target_address_r;
    output reg port_change_flag_clear_r;
    output reg port_latch_copy_r;
    output reg [`PH_W-1:0] phase_r;

    localparam ST_FIRST = 3'b001;
    localparam ST_SECOND = 3'b010;
    localparam ST_FLUSH = 3'b100;

    // second word of a pair, called only by the lone-word check
    function is_second_word;
        input [`WORD_W-1:0] w;
        begin
            is_second_word = (w[`NIB_HI:`NIB_LO] == `NIB_SECOND);
        end
    endfunction

    function [`LIT_W-1:0] sext;
        input [`REL11_HI:0] v;
        input short8;
        begin
            if (short8) begin
                sext = {{(`LIT_W-8){v[`REL8_SIGN]}}, v[`K8_HI:0]};
            end else begin
                sext = {{(`LIT_W-11){v[`REL11_SIGN]}}, v};
            end
        end
    endfunction

    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [`WORD_W-1:0] ir_r;
    reg [`WORD_W-1:0] first_r;
    reg [`KIND_W-1:0] kind_hold_r;
    reg [`CNT_W-1:0] cyc_cnt_r;
    reg [7:0] ctrl_r;
    reg [`WORD_W-1:0] last_word_r;
    reg [`ADDR_W-1:0] src_hold_r;

    wire [`PH_W-1:0] phase;
    wire cycle_end;
    wire dest_file;
    wire access_bsr;
    wire [2:0] bit_num;
    wire [`ADDR_W-1:0] full_addr;
    wire [1:0] tmode;
    wire run_en;
    wire lone_second;
    wire is_double;
    wire reads_file;
    wire writes_file;
    wire pc_change;
    wire skip_taken;
    wire [`ADDR_W-1:0] rd_addr;
    wire [`ADDR_W-1:0] move_target;

    phase_divider u_phase (
        .clk(clk),
        .nrst(nrst),
        .phase(phase),
        .cycle_end(cycle_end)
    );

    field_split u_fields (
        .word(ir_r),
        .bank_select_register(bank_select_register),
        .dest_file(dest_file),
        .access_bsr(access_bsr),
        .bit_num(bit_num),
        .full_addr(full_addr),
        .tmode(tmode)
    );

    assign run_en = ctrl_r[`CTRL_RUN];
    assign lone_second = (state_r == ST_FIRST) && is_second_word(ir_r);
    assign is_double = (instr_kind == `K_MOVE) || (instr_kind == `K_LONG) ||
        (instr_kind == `K_CALL) || (instr_kind == `K_LIT12);
    // every file-register form reads before any write, even pure writes
    assign reads_file = !lone_second && ((instr_kind == `K_BYTE) || (instr_kind == `K_BIT) ||
        (instr_kind == `K_SKIP));
    assign writes_file = !lone_second && (((instr_kind == `K_BYTE) && dest_file) ||
        (instr_kind == `K_BIT));
    assign pc_change = (instr_kind == `K_BRA_REL) || (instr_kind == `K_RET) ||
        ((instr_kind == `K_COND_REL) && cond_true);
    assign skip_taken = (instr_kind == `K_SKIP) && cond_true;
    assign move_target = ir_r[`F12_HI:0];
    assign rd_addr = (state_r == ST_FIRST && instr_kind == `K_MOVE) ? ir_r[`F12_HI:0] : full_addr;

    // instruction sequencing, decided once per instruction cycle
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_FIRST: begin
                if (!run_en || lone_second) begin
                    state_nxt = ST_FIRST;
                end else if (is_double) begin
                    state_nxt = ST_SECOND;
                end else if (pc_change || skip_taken) begin
                    state_nxt = ST_FLUSH;
                end
            end
            ST_SECOND: begin
                if (kind_hold_r == `K_LONG && cond_true) begin
                    state_nxt = ST_FLUSH;
                end else begin
                    state_nxt = ST_FIRST;
                end
            end
            ST_FLUSH: begin
                state_nxt = ST_FIRST;
            end
            default: begin
                state_nxt = ST_FIRST;
            end
        endcase
    end

    always @(posedge clk) begin
        if (!nrst) begin
            state_r <= ST_FIRST;
            ir_r <= {`WORD_W{1'b0}};
            first_r <= {`WORD_W{1'b0}};
            kind_hold_r <= `K_CTRL;
            cyc_cnt_r <= `ONE_CYC;
            src_hold_r <= {`ADDR_W{1'b0}};
            last_word_r <= {`WORD_W{1'b0}};
            phase_r <= {`PH_W{1'b0}};
            instr_word_r <= {`WORD_W{1'b0}};
            opcode_r <= {`OPC_W{1'b0}};
            file_rd_r <= 1'b0;
            file_wr_r <= 1'b0;
            file_addr_r <= {`ADDR_W{1'b0}};
            bit_num_r <= 3'h0;
            dest_accum_r <= 1'b0;
            working_accumulator_wr_r <= 1'b0;
            literal_r <= {`LIT_W{1'b0}};
            target_r <= {`LIT_W{1'b0}};
            rel_offset_r <= {`LIT_W{1'b0}};
            pc_load_r <= 1'b0;
            fetch_discard_r <= 1'b0;
            exec_nop_r <= 1'b0;
            instr_done_r <= 1'b0;
            cycles_used_r <= `ONE_CYC;
            shadow_save_r <= 1'b0;
            shadow_restore_r <= 1'b0;
            table_pointer_mode_r <= `MM_NONE;
            table_op_r <= 1'b0;
            move_source_address_r <= {`ADDR_W{1'b0}};
            move_target_address_r <= {`ADDR_W{1'b0}};
            port_change_flag_clear_r <= 1'b0;
            port_latch_copy_r <= 1'b0;
        end else begin
            phase_r <= phase;
            instr_word_r <= ir_r;
            opcode_r <= ir_r[`OPC_HI:`OPC_LO];
            bit_num_r <= bit_num;
            dest_accum_r <= !dest_file;
            // read early in the cycle, write back at its end
            file_rd_r <= 1'b0;
            file_wr_r <= 1'b0;
            port_change_flag_clear_r <= 1'b0;
            port_latch_copy_r <= 1'b0;
            working_accumulator_wr_r <= 1'b0;
            pc_load_r <= 1'b0;
            fetch_discard_r <= 1'b0;
            exec_nop_r <= 1'b0;
            instr_done_r <= 1'b0;
            shadow_save_r <= 1'b0;
            shadow_restore_r <= 1'b0;
            table_op_r <= 1'b0;
            if (phase == `PH_READ && run_en && state_r == ST_FIRST &&
                (reads_file || (instr_kind == `K_MOVE && !lone_second))) begin
                file_rd_r <= 1'b1;
                file_addr_r <= rd_addr;
                // the read side effect hits the port even for write-only forms
                if (rd_addr == `PORT_B_ADDR) begin
                    port_change_flag_clear_r <= 1'b1;
                end
            end
            if (cycle_end) begin
                ir_r <= prog_word;
                state_r <= state_nxt;
                cyc_cnt_r <= cyc_cnt_r + `ONE_CYC;
                case (state_r)
                    ST_FIRST: begin
                        if (!run_en || lone_second) begin
                            exec_nop_r <= 1'b1;
                            instr_done_r <= run_en;
                            cycles_used_r <= `ONE_CYC;
                            cyc_cnt_r <= `ONE_CYC;
                        end else if (is_double) begin
                            first_r <= ir_r;
                            kind_hold_r <= instr_kind;
                            src_hold_r <= ir_r[`F12_HI:0];
                        end else begin
                            last_word_r <= ir_r;
                            if (writes_file) begin
                                file_wr_r <= 1'b1;
                                file_addr_r <= full_addr;
                                port_latch_copy_r <= (full_addr == `PORT_B_ADDR);
                            end
                            working_accumulator_wr_r <= (instr_kind == `K_BYTE) && !dest_file;
                            if (instr_kind == `K_LIT8) begin
                                literal_r <= {{(`LIT_W-8){1'b0}}, ir_r[`K8_HI:0]};
                                working_accumulator_wr_r <= 1'b1;
                            end
                            if (instr_kind == `K_BRA_REL || instr_kind == `K_COND_REL) begin
                                rel_offset_r <= sext(ir_r[`REL11_HI:0], instr_kind == `K_COND_REL);
                                pc_load_r <= pc_change;
                            end
                            if (instr_kind == `K_RET) begin
                                pc_load_r <= 1'b1;
                                shadow_restore_r <= ir_r[`S_RET_BIT];
                            end
                            if (instr_kind == `K_TBL) begin
                                table_op_r <= 1'b1;
                                table_pointer_mode_r <= tmode;
                            end
                            if (pc_change || skip_taken) begin
                                fetch_discard_r <= 1'b1;
                            end else begin
                                instr_done_r <= 1'b1;
                                cycles_used_r <= `ONE_CYC;
                                cyc_cnt_r <= `ONE_CYC;
                            end
                        end
                    end
                    ST_SECOND: begin
                        last_word_r <= first_r;
                        case (kind_hold_r)
                            `K_MOVE: begin
                                move_source_address_r <= src_hold_r;
                                move_target_address_r <= move_target;
                                file_wr_r <= 1'b1;
                                file_addr_r <= move_target;
                                port_latch_copy_r <= (move_target == `PORT_B_ADDR);
                            end
                            `K_LIT12: begin
                                literal_r <= {{(`LIT_W-12){1'b0}}, first_r[`K4_HI:0], ir_r[`K8_HI:0]};
                            end
                            `K_LONG, `K_CALL: begin
                                target_r <= {ir_r[`F12_HI:0], first_r[`K8_HI:0]};
                                literal_r <= {ir_r[`F12_HI:0], first_r[`K8_HI:0]};
                                pc_load_r <= (kind_hold_r == `K_CALL) || cond_true;
                                shadow_save_r <= (kind_hold_r == `K_CALL) && first_r[`S_CALL_BIT];
                            end
                            default: begin
                                exec_nop_r <= 1'b1;
                            end
                        endcase
                        if (kind_hold_r == `K_LONG && cond_true) begin
                            fetch_discard_r <= 1'b1;
                        end else begin
                            instr_done_r <= 1'b1;
                            cycles_used_r <= `TWO_CYC;
                            cyc_cnt_r <= `ONE_CYC;
                        end
                    end
                    ST_FLUSH: begin
                        // discarded prefetch runs as a no-operation
                        exec_nop_r <= 1'b1;
                        instr_done_r <= 1'b1;
                        cycles_used_r <= cyc_cnt_r;
                        cyc_cnt_r <= `ONE_CYC;
                    end
                    default: begin
                        exec_nop_r <= 1'b1;
                    end
                endcase
            end
        end
    end

    // register port: answer one cycle after the read strobe, never stalls
    always @(posedge clk) begin
        if (!nrst) begin
            ctrl_r <= `CTRL_RESET;
            reg_rdata <= `BYTE_ZERO;
        end else begin
            if (reg_wr && reg_addr == `RA_CTRL) begin
                ctrl_r <= reg_wdata;
            end
            reg_rdata <= `BYTE_ZERO;
            if (reg_rd) begin
                case (reg_addr)
                    `RA_CTRL: reg_rdata <= ctrl_r;
                    `RA_STATUS: reg_rdata <= {1'b0, state_r, cycles_used_r, phase_r};
                    `RA_WORD_LO: reg_rdata <= last_word_r[7:0];
                    `RA_WORD_HI: reg_rdata <= last_word_r[15:8];
                    default: reg_rdata <= `BYTE_ZERO;
                endcase
            end
        end
    end
endmodule // instruction_word_decode

// [instruction_word_decode_properties.sv]
`include "decode_regs.vh"
module iwd_checker (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [15:0] instr_word_r,
    input wire logic [5:0] opcode_r,
    input wire logic file_rd_r,
    input wire logic file_wr_r,
    input wire logic [11:0] file_addr_r,
    input wire logic exec_nop_r,
    input wire logic instr_done_r,
    input wire logic [1:0] cycles_used_r,
    input wire logic fetch_discard_r,
    input wire logic shadow_save_r,
    input wire logic shadow_restore_r,
    input wire logic port_change_flag_clear_r,
    input wire logic port_latch_copy_r,
    input wire logic [1:0] phase_r
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // remembers a read inside the running instruction until it completes
    logic rd_seen_r;
    always @(posedge clk) begin
        if (!nrst) begin
            rd_seen_r <= 1'b0;
        end else if (file_rd_r) begin
            rd_seen_r <= 1'b1;
        end else if (instr_done_r) begin
            rd_seen_r <= 1'b0;
        end
    end

    a_phase_steps: assert property ($past(nrst) && $past(nrst, 2) && $past(nrst, 3) |->
        phase_r == $past(phase_r) + 2'h1) else $error("phase does not advance by one");
    a_done_gap: assert property (instr_done_r |=> !instr_done_r [*3])
        else $error("two completions inside one instruction cycle");
    a_opcode_field: assert property (opcode_r == instr_word_r[15:10])
        else $error("opcode not taken from the top six bits");
    a_rmw_order: assert property (file_wr_r |-> rd_seen_r || file_rd_r)
        else $error("file write without a preceding read");
    a_flag_clear: assert property (port_change_flag_clear_r == (file_rd_r && file_addr_r == `PORT_B_ADDR))
        else $error("port change flag clear does not follow a port read");
    a_latch_copy: assert property (port_latch_copy_r |-> file_wr_r && file_addr_r == `PORT_B_ADDR)
        else $error("latch copy without a port write");
    a_flush_nop: assert property (fetch_discard_r |-> ##4 exec_nop_r)
        else $error("dropped word not replaced by a no-operation cycle");
    a_flush_cost: assert property (fetch_discard_r |-> ##4 (instr_done_r && cycles_used_r != `ONE_CYC))
        else $error("flushed instruction reported as one cycle");
    a_shadow_excl: assert property (!(shadow_save_r && shadow_restore_r))
        else $error("shadow save and restore together");

    cover property (instr_done_r && cycles_used_r == `THREE_CYC);
    cover property (port_change_flag_clear_r);
    cover property (shadow_restore_r);
    cover property (shadow_save_r);
    cover property (port_latch_copy_r);
endmodule // iwd_checker

bind instruction_word_decode iwd_checker u_checker (.*);

// [phase_divider.v]
`include "decode_regs.vh"

module phase_divider (
    clk,
    nrst,
    phase,
    cycle_end
);
    input wire clk;
    input wire nrst;
    output reg [`PH_W-1:0] phase;
    output wire cycle_end;

    // free-running so the four phases stay aligned to reset release
    always @(posedge clk) begin
        if (!nrst) begin
            phase <= {`PH_W{1'b0}};
        end else begin
            phase <= phase + `PH_STEP;
        end
    end

    assign cycle_end = (phase == `PH_LAST);
endmodule // phase_divider

// [prog_fetch_model.sv]
`include "decode_regs.vh"
module prog_fetch_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [1:0] phase_r,
    output logic [15:0] prog_word,
    output logic [3:0] instr_kind
);
    timeunit 1ns;
    timeprecision 1ps;
    // entries are {kind, word}; second words carry the control kind
    logic [19:0] prog [0:31];
    logic [4:0] pc_r;
    assign prog_word = prog[pc_r][15:0];
    // no jump is modelled, so the program pads every dropped prefetch slot
    always @(posedge clk) begin
        if (!nrst) begin
            pc_r <= 5'h00;
            instr_kind <= `K_CTRL;
        end else if (phase_r == 2'h2) begin
            pc_r <= (pc_r == 5'h1F) ? pc_r : pc_r + 5'h01;
            instr_kind <= prog[pc_r][19:16];
        end
    end
endmodule // prog_fetch_model

// [tb_instruction_word_decode.sv]
`include "decode_regs.vh"
module tb_instruction_word_decode;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, nrst = 1'b0, cond_true = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] bank_select_register = 4'h5;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic [15:0] prog_word, instr_word_r;
    logic [3:0] instr_kind;
    logic [5:0] opcode_r;
    logic [11:0] file_addr_r, move_source_address_r, move_target_address_r, rd_a;
    logic [2:0] bit_num_r;
    logic [19:0] literal_r, target_r, rel_offset_r;
    logic [1:0] cycles_used_r, table_pointer_mode_r, phase_r;
    logic file_rd_r, file_wr_r, dest_accum_r, working_accumulator_wr_r, pc_load_r, fetch_discard_r;
    logic exec_nop_r, instr_done_r, shadow_save_r, shadow_restore_r, table_op_r;
    logic port_change_flag_clear_r, port_latch_copy_r;
    logic armed = 1'b0, wr_s = 1'b0, acc_s = 1'b0, pf_s = 1'b0, sh_s = 1'b0, nop_s = 1'b0, disc_s = 1'b0;
    logic lc_s = 1'b0, sv_s = 1'b0;
    int num_errors = 0, n_tests = 0, idx = 0, ndone = 0, snap = 0;
    // two bits of expected cycle count per completed instruction, first at the bottom
    localparam logic [35:0] CYC = 36'hAABA55595;
    localparam logic [19:0] PROG [0:27] = '{20'h02734, 20'h02481, 20'h19B12, 20'h3C123, 20'hCFF81,
        20'hCF555, 20'hA0008, 20'hA0009, 20'hA000A, 20'hA000B, 20'h20E7F, 20'h6EE05, 20'hCF0A5,
        20'h7D7FE, 20'hC0000, 20'h4EF56, 20'hCF234, 20'hC0000, 20'h90013, 20'hC0000, 20'h90012,
        20'hC0000, 20'h5ED34, 20'hCF012, 20'h8E3F0, 20'hC0000, 20'hB6B22, 20'hC0000};

    always #2 clk = ~clk;
    instruction_word_decode dut (.*);
    prog_fetch_model mem (.*);

    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // d is write data, or the expected read value under mask m
    task automatic reg_acc(input logic w, input logic [2:0] a, input logic [7:0] d, input logic [7:0] m);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(negedge clk);
        if (!w) chk(reg_rdata & m, d);
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic check_instr();
        chk(cycles_used_r, (idx < 18) ? CYC[2*idx+:2] : 2'h1);
        if (idx == 0) chk(opcode_r, 6'h09);
        if (idx == 0) chk(dest_accum_r, 1'b0);
        if (idx == 0) chk(lc_s, 1'b0);
        if (idx == 1) chk(dest_accum_r, 1'b1);
        if (idx == 0) chk(rd_a, 12'h534);
        if (idx == 0) chk(wr_s, 1'b1);
        if (idx == 1) chk(rd_a, 12'hF81);
        if (idx == 1) chk(acc_s, 1'b1);
        if (idx == 1) chk(pf_s, 1'b1);
        if (idx == 2) chk(rd_a, 12'h512);
        if (idx == 2) chk(bit_num_r, 3'h5);
        if (idx == 3) chk(move_source_address_r, 12'h123);
        if (idx == 3) chk(move_target_address_r, 12'hF81);
        if (idx == 3) chk(lc_s, 1'b1);
        if (idx == 4) chk(nop_s, 1'b1);
        if (idx >= 5 && idx <= 8) chk(table_pointer_mode_r, 20'(idx - 5));
        if (idx == 9) chk(literal_r, 20'h0007F);
        if (idx == 10) chk(literal_r, 20'h005A5);
        if (idx == 11) chk(rel_offset_r, 20'hFFFFE);
        if (idx == 11) chk(disc_s, 1'b1);
        if (idx == 12) chk(target_r, 20'h23456);
        if (idx == 13) chk(sh_s, 1'b1);
        if (idx == 14) chk(sh_s, 1'b0);
        if (idx == 15) chk(target_r, 20'h01234);
        if (idx == 15) chk(sv_s, 1'b1);
        if (idx == 16) chk(rel_offset_r, 20'hFFFF0);
        if (idx == 17) chk(rd_a, 12'h522);
        if (idx == 17) chk(disc_s, 1'b1);
        idx++;
    endtask

    // sampled mid-cycle so every registered pulse has settled
    always @(negedge clk) begin
        if (file_rd_r) begin
            armed = 1'b1;
            rd_a = file_addr_r;
        end
        wr_s |= file_wr_r;
        acc_s |= working_accumulator_wr_r;
        pf_s |= port_change_flag_clear_r;
        sh_s |= shadow_restore_r;
        nop_s |= exec_nop_r;
        disc_s |= fetch_discard_r;
        lc_s |= port_latch_copy_r;
        sv_s |= shadow_save_r;
        if (instr_done_r) begin
            ndone++;
            if (armed) check_instr();
            {wr_s, acc_s, pf_s, sh_s, nop_s, disc_s, lc_s, sv_s} = '0;
        end
    end

    initial begin
        for (int i = 0; i < 32; i++) mem.prog[i] = (i < 28) ? PROG[i] : 20'hC0000;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        reg_acc(1'b0, `RA_STATUS, 8'h14, 8'h7C);
        reg_acc(1'b0, `RA_CTRL, 8'h01, 8'hFF);
        $display("test reset_values done");
        for (int i = 0; i < 400 && idx < 18; i++) @(posedge clk);
        chk(20'(idx), 20'h00012);
        $display("test decode_sequence done");
        reg_acc(1'b1, `RA_CTRL, 8'h00, 8'h00);
        repeat (4) @(posedge clk);
        snap = ndone;
        repeat (20) @(posedge clk);
        chk(20'(ndone - snap), 20'h00000);
        reg_acc(1'b0, `RA_CTRL, 8'h00, 8'hFF);
        reg_acc(1'b0, 3'h5, 8'h00, 8'hFF);
        reg_acc(1'b1, `RA_CTRL, 8'h01, 8'h00);
        $display("test run_stop done");
        report_and_stop();
    end

    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        report_and_stop();
    end
endmodule // tb_instruction_word_decode
